//--- shared/ppc_map.svh
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

// Register offsets on the plain register port
`define PPC_OFF_P_DRIVE     4'h0
`define PPC_OFF_P_PULL      4'h1
`define PPC_OFF_P_POLARITY  4'h2
`define PPC_OFF_P_IRQ_EN    4'h3
`define PPC_OFF_P_IRQ_FLAGS 4'h4
`define PPC_OFF_RSVD_0      4'h5
`define PPC_OFF_RSVD_1      4'h6
`define PPC_OFF_RSVD_2      4'h7
`define PPC_OFF_J_DATA      4'h8
`define PPC_OFF_J_READBACK  4'h9
`define PPC_OFF_J_DIRECTION 4'ha

// Implemented bit positions of each port
`define PPC_P_MASK          8'hbf
`define PPC_J_MASK          8'hc7

// Reset values
`define PPC_RST_REG         8'h00
`define PPC_RST_RSVD_READ   8'h00

// Synchroniser depth ahead of edge detection, in flip-flops
`define PPC_SYNC_STAGES     2

`endif

//--- shared/ppc_pkg.sv
`default_nettype none

package ppc_pkg;

    // One port-wide byte
    typedef logic [7:0] ppc_byte_t;

    // Register port address
    typedef logic [3:0] ppc_addr_t;

    // Register selected by an address
    typedef enum logic [3:0] {
        PPC_SEL_NONE      = 4'b0000,
        PPC_SEL_P_DRIVE   = 4'b0001,
        PPC_SEL_P_PULL    = 4'b0010,
        PPC_SEL_P_POL     = 4'b0011,
        PPC_SEL_P_IRQ_EN  = 4'b0100,
        PPC_SEL_P_FLAGS   = 4'b0101,
        PPC_SEL_RSVD      = 4'b0110,
        PPC_SEL_J_DATA    = 4'b0111,
        PPC_SEL_J_READ    = 4'b1000,
        PPC_SEL_J_DIR     = 4'b1001
    } ppc_sel_t;

endpackage

`default_nettype wire

//--- verilog/ppc_port.sv
// The register addresses and strobed register access were chosen for this implementation.
`include "ppc_map.svh"

`default_nettype none

// Summary of operation
// - Drive-select one gives reduced drive on the pin, zero gives full drive.
// - Drive select is ignored while the pin is an input.
// - Drive select applies whether GPIO or an alternate function drives the pin.
// - Pull-enable one switches the pin's pull device on, zero switches it off.
// - Pull enable is ignored while the pin is an output.
// - Polarity one: pull-down and rising edge; zero: pull-up and falling edge.
// - Interrupt enable one lets the flag request; zero masks the flag.
// - An edge of the selected polarity on a pin sets its flag.
// - Writing one to a flag bit clears that flag.
// - Interrupt request is high while any flag is set with its enable set.
// - Reserved registers read zero and ignore writes.
// - A second-port output pin is driven with its data bit.
// - Data read gives the stored bit for outputs, the pin state for inputs.
// - Pin edge interrupts work in input and in output mode.
// - Readback register always gives the pin state; writes do nothing.
// - Second-port direction one makes an output, zero an input.
// - All configuration, flag, data and direction registers are accessible anytime.
module ppc_port #(
    parameter int SYNC_STAGES = `PPC_SYNC_STAGES
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               srst,

    // Register port
    input  wire ppc_pkg::ppc_addr_t reg_addr,
    input  wire ppc_pkg::ppc_byte_t reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output var  ppc_pkg::ppc_byte_t reg_rdata,

    // First port pins and the direction owned by its data/direction logic
    input  wire ppc_pkg::ppc_byte_t p_pin_in,
    input  wire ppc_pkg::ppc_byte_t p_pin_is_output,
    output var  ppc_pkg::ppc_byte_t p_reduced_drive,
    output var  ppc_pkg::ppc_byte_t p_pull_on,
    output var  ppc_pkg::ppc_byte_t p_pull_down,

    // First port interrupt request
    output var  logic               p_irq,

    // Second port pins
    input  wire ppc_pkg::ppc_byte_t j_pin_in,
    output var  ppc_pkg::ppc_byte_t j_pin_out,
    output var  ppc_pkg::ppc_byte_t j_pin_oe_n
);

    // Address decode, shared by the write and the read path
    function automatic ppc_pkg::ppc_sel_t decode_addr(input ppc_pkg::ppc_addr_t addr);
        ppc_pkg::ppc_sel_t sel;
        sel = ppc_pkg::PPC_SEL_NONE;
        case (addr)
            `PPC_OFF_P_DRIVE: begin
                sel = ppc_pkg::PPC_SEL_P_DRIVE;
            end
            `PPC_OFF_P_PULL: begin
                sel = ppc_pkg::PPC_SEL_P_PULL;
            end
            `PPC_OFF_P_POLARITY: begin
                sel = ppc_pkg::PPC_SEL_P_POL;
            end
            `PPC_OFF_P_IRQ_EN: begin
                sel = ppc_pkg::PPC_SEL_P_IRQ_EN;
            end
            `PPC_OFF_P_IRQ_FLAGS: begin
                sel = ppc_pkg::PPC_SEL_P_FLAGS;
            end
            `PPC_OFF_RSVD_0, `PPC_OFF_RSVD_1, `PPC_OFF_RSVD_2: begin
                sel = ppc_pkg::PPC_SEL_RSVD;
            end
            `PPC_OFF_J_DATA: begin
                sel = ppc_pkg::PPC_SEL_J_DATA;
            end
            `PPC_OFF_J_READBACK: begin
                sel = ppc_pkg::PPC_SEL_J_READ;
            end
            `PPC_OFF_J_DIRECTION: begin
                sel = ppc_pkg::PPC_SEL_J_DIR;
            end
            default: begin
                sel = ppc_pkg::PPC_SEL_NONE;
            end
        endcase
        return sel;
    endfunction

    // Pin synchronisers: stage 0 is read only by stage 1
    ppc_pkg::ppc_byte_t p_sync [SYNC_STAGES];
    ppc_pkg::ppc_byte_t j_sync [SYNC_STAGES];
    ppc_pkg::ppc_byte_t p_prev;
    ppc_pkg::ppc_byte_t next_p_prev;

    // Configuration and state registers
    ppc_pkg::ppc_byte_t first_port_drive_select;
    ppc_pkg::ppc_byte_t first_port_pull_enable;
    ppc_pkg::ppc_byte_t first_port_polarity_select;
    ppc_pkg::ppc_byte_t first_port_irq_enable;
    ppc_pkg::ppc_byte_t first_port_irq_flags;
    ppc_pkg::ppc_byte_t second_port_output_data;
    ppc_pkg::ppc_byte_t second_port_direction;

    ppc_pkg::ppc_byte_t next_first_port_drive_select;
    ppc_pkg::ppc_byte_t next_first_port_pull_enable;
    ppc_pkg::ppc_byte_t next_first_port_polarity_select;
    ppc_pkg::ppc_byte_t next_first_port_irq_enable;
    ppc_pkg::ppc_byte_t next_first_port_irq_flags;
    ppc_pkg::ppc_byte_t next_second_port_output_data;
    ppc_pkg::ppc_byte_t next_second_port_direction;

    // Output and read-data next values
    ppc_pkg::ppc_byte_t next_reg_rdata;
    ppc_pkg::ppc_byte_t next_p_reduced_drive;
    ppc_pkg::ppc_byte_t next_p_pull_on;
    ppc_pkg::ppc_byte_t next_p_pull_down;
    logic               next_p_irq;
    ppc_pkg::ppc_byte_t next_j_pin_out;
    ppc_pkg::ppc_byte_t next_j_pin_oe_n;

    // Decoded access and edge events
    ppc_pkg::ppc_sel_t  wr_sel;
    ppc_pkg::ppc_sel_t  rd_sel;
    ppc_pkg::ppc_byte_t p_synced;
    ppc_pkg::ppc_byte_t j_synced;
    ppc_pkg::ppc_byte_t p_edge;

    // Strobe-qualified selects; a read never has side effects on any register
    assign wr_sel   = reg_wr ? decode_addr(reg_addr) : ppc_pkg::PPC_SEL_NONE;
    assign rd_sel   = reg_rd ? decode_addr(reg_addr) : ppc_pkg::PPC_SEL_NONE;
    assign p_synced = p_sync[SYNC_STAGES-1];
    assign j_synced = j_sync[SYNC_STAGES-1];

    // Synchroniser chains, no reset needed since pins settle within a few cycles
    always_ff @(posedge clk) begin
        p_sync[0] <= p_pin_in & `PPC_P_MASK;
        j_sync[0] <= j_pin_in & `PPC_J_MASK;
    end

    // Depth is a parameter; more stages buy metastability margin for extra latency
    generate
        for (genvar s = 1; s < SYNC_STAGES; s++) begin : g_sync
            // Later synchroniser stages
            always_ff @(posedge clk) begin
                p_sync[s] <= p_sync[s-1];
                j_sync[s] <= j_sync[s-1];
            end
        end
    endgenerate

    // Per-pin edge detect; pin state is seen whatever the direction
    // A pin pulse shorter than one clock can be missed; pins are sampled, not latched
    generate
        for (genvar i = 0; i < 8; i++) begin : g_edge
            // Rising when polarity is one, falling when zero
            assign p_edge[i] = first_port_polarity_select[i]
                               ? (p_synced[i] & ~p_prev[i])
                               : (~p_synced[i] & p_prev[i]);
        end
    endgenerate

    // Previous sample tracks the synchronised pins
    always_comb begin
        next_p_prev = p_synced;
    end

    // Previous sample; reset polarity is falling, so a low start cannot fake an edge
    always_ff @(posedge clk) begin
        if (srst) begin
            p_prev <= `PPC_RST_REG;
        end else begin
            p_prev <= next_p_prev;
        end
    end

    // Register file writes; every configuration, data and direction register is writable at any time
    always_comb begin
        next_first_port_drive_select    = first_port_drive_select;
        next_first_port_pull_enable     = first_port_pull_enable;
        next_first_port_polarity_select = first_port_polarity_select;
        next_first_port_irq_enable      = first_port_irq_enable;
        next_second_port_output_data    = second_port_output_data;
        next_second_port_direction      = second_port_direction;
        // Flags are written in their own process below
        case (wr_sel)
            ppc_pkg::PPC_SEL_P_DRIVE: begin
                next_first_port_drive_select = reg_wdata & `PPC_P_MASK;
            end
            ppc_pkg::PPC_SEL_P_PULL: begin
                next_first_port_pull_enable = reg_wdata & `PPC_P_MASK;
            end
            ppc_pkg::PPC_SEL_P_POL: begin
                next_first_port_polarity_select = reg_wdata & `PPC_P_MASK;
            end
            ppc_pkg::PPC_SEL_P_IRQ_EN: begin
                next_first_port_irq_enable = reg_wdata & `PPC_P_MASK;
            end
            ppc_pkg::PPC_SEL_J_DATA: begin
                next_second_port_output_data = reg_wdata & `PPC_J_MASK;
            end
            ppc_pkg::PPC_SEL_J_DIR: begin
                next_second_port_direction = reg_wdata & `PPC_J_MASK;
            end
            default: begin
                // Reserved, readback and unmapped writes are dropped
                next_second_port_direction = second_port_direction;
            end
        endcase
    end

    // Configuration, data and direction registers
    always_ff @(posedge clk) begin
        if (srst) begin
            first_port_drive_select    <= `PPC_RST_REG;
            first_port_pull_enable     <= `PPC_RST_REG;
            first_port_polarity_select <= `PPC_RST_REG;
            first_port_irq_enable      <= `PPC_RST_REG;
            second_port_output_data    <= `PPC_RST_REG;
            second_port_direction      <= `PPC_RST_REG;
        end else begin
            first_port_drive_select    <= next_first_port_drive_select;
            first_port_pull_enable     <= next_first_port_pull_enable;
            first_port_polarity_select <= next_first_port_polarity_select;
            first_port_irq_enable      <= next_first_port_irq_enable;
            second_port_output_data    <= next_second_port_output_data;
            second_port_direction      <= next_second_port_direction;
        end
    end

    // Flags: an edge in the same cycle as a clearing write wins, so no event is lost
    always_comb begin
        next_first_port_irq_flags = first_port_irq_flags;
        if (wr_sel == ppc_pkg::PPC_SEL_P_FLAGS) begin
            next_first_port_irq_flags = first_port_irq_flags & ~reg_wdata;
        end
        // New edges are merged after the clear, so the set wins
        next_first_port_irq_flags = (next_first_port_irq_flags | p_edge)
                                    & `PPC_P_MASK;
    end

    // Pending edge flags
    always_ff @(posedge clk) begin
        if (srst) begin
            first_port_irq_flags <= `PPC_RST_REG;
        end else begin
            first_port_irq_flags <= next_first_port_irq_flags;
        end
    end

    // Read path: data stand one cycle after the strobe, zero otherwise
    always_comb begin
        next_reg_rdata = `PPC_RST_REG;
        case (rd_sel)
            ppc_pkg::PPC_SEL_P_DRIVE: begin
                next_reg_rdata = first_port_drive_select;
            end
            ppc_pkg::PPC_SEL_P_PULL: begin
                next_reg_rdata = first_port_pull_enable;
            end
            ppc_pkg::PPC_SEL_P_POL: begin
                next_reg_rdata = first_port_polarity_select;
            end
            ppc_pkg::PPC_SEL_P_IRQ_EN: begin
                next_reg_rdata = first_port_irq_enable;
            end
            ppc_pkg::PPC_SEL_P_FLAGS: begin
                next_reg_rdata = first_port_irq_flags;
            end
            ppc_pkg::PPC_SEL_RSVD: begin
                next_reg_rdata = `PPC_RST_RSVD_READ;
            end
            ppc_pkg::PPC_SEL_J_DATA: begin
                // Outputs show the stored bit, inputs the pin
                next_reg_rdata = (second_port_output_data & second_port_direction)
                                 | (j_synced & ~second_port_direction);
            end
            ppc_pkg::PPC_SEL_J_READ: begin
                // Ignores direction, so a shorted output pin shows here
                next_reg_rdata = j_synced;
            end
            ppc_pkg::PPC_SEL_J_DIR: begin
                next_reg_rdata = second_port_direction;
            end
            default: begin
                next_reg_rdata = `PPC_RST_REG;
            end
        endcase
    end

    // Read data; zero between reads so a late sample cannot look like data
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= `PPC_RST_REG;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // Pad controls; all registered, so they follow register changes by one cycle
    always_comb begin
        // Alternate functions share the same drive control, no override needed
        // First port direction arrives from the port's own data and direction logic
        next_p_reduced_drive = first_port_drive_select
                               & p_pin_is_output;
        next_p_pull_on       = first_port_pull_enable & ~p_pin_is_output
                               & `PPC_P_MASK;
        // Pull-down when polarity is one, pull-up otherwise
        next_p_pull_down     = first_port_polarity_select & next_p_pull_on;
        // Level request from any enabled pending flag
        next_p_irq           = |(first_port_irq_flags & first_port_irq_enable);
        next_j_pin_out       = second_port_output_data & second_port_direction;
        // Enable is active low and follows the direction bit
        next_j_pin_oe_n      = ~(second_port_direction & `PPC_J_MASK);
    end

    // Pad controls and request; the block's outputs come straight from these flops
    // Every second-port pad is released while reset is held
    always_ff @(posedge clk) begin
        if (srst) begin
            p_reduced_drive <= `PPC_RST_REG;
            p_pull_on       <= `PPC_RST_REG;
            p_pull_down     <= `PPC_RST_REG;
            p_irq           <= 1'b0;
            j_pin_out       <= `PPC_RST_REG;
            j_pin_oe_n      <= ~`PPC_RST_REG;
        end else begin
            p_reduced_drive <= next_p_reduced_drive;
            p_pull_on       <= next_p_pull_on;
            p_pull_down     <= next_p_pull_down;
            p_irq           <= next_p_irq;
            j_pin_out       <= next_j_pin_out;
            j_pin_oe_n      <= next_j_pin_oe_n;
        end
    end

endmodule // ppc_port

`default_nettype wire

//--- tb/ppc_board.sv
`default_nettype none

// Board side of the pins: levels the bench commands, merged with the device's pad drive
module ppc_board (
    // Levels the bench wants the board to present
    input  wire ppc_pkg::ppc_byte_t p_ext,
    input  wire ppc_pkg::ppc_byte_t j_ext,
    // Second port pad drive from the device
    input  wire ppc_pkg::ppc_byte_t j_pin_out,
    input  wire ppc_pkg::ppc_byte_t j_pin_oe_n,
    // Levels seen at the device's input buffers
    output logic [7:0]              p_pin_in,
    output logic [7:0]              j_pin_in
);
    // First port has no pad drive in this block, so the board alone sets it
    assign p_pin_in = p_ext;
    // A driven pin shows the device's level; the board only wins where the pad is off
    assign j_pin_in = (j_pin_out & ~j_pin_oe_n) | (j_ext & j_pin_oe_n);
endmodule // ppc_board

`default_nettype wire

//--- tb/ppc_port_properties.sv
`default_nettype none

// Timing and masking relations at the ports of ppc_port
module ppc_port_properties #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input wire logic               clk,
    input wire logic               srst,
    // Register port
    input wire ppc_pkg::ppc_addr_t reg_addr,
    input wire ppc_pkg::ppc_byte_t reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire ppc_pkg::ppc_byte_t reg_rdata,
    // Pads and request
    input wire ppc_pkg::ppc_byte_t p_pin_in,
    input wire ppc_pkg::ppc_byte_t p_pin_is_output,
    input wire ppc_pkg::ppc_byte_t p_reduced_drive,
    input wire ppc_pkg::ppc_byte_t p_pull_on,
    input wire ppc_pkg::ppc_byte_t p_pull_down,
    input wire logic               p_irq,
    input wire ppc_pkg::ppc_byte_t j_pin_in,
    input wire ppc_pkg::ppc_byte_t j_pin_out,
    input wire ppc_pkg::ppc_byte_t j_pin_oe_n
);
    logic [2:0] rst_age;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Age since reset; the synchroniser chains have no reset, so they need a few cycles after release to settle
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_age <= 3'h0;
        end else if (rst_age != 3'h7) begin
            rst_age <= rst_age + 3'h1;
        end
    end

    a_drive_input_off: assert property (
        (p_reduced_drive & ~$past(p_pin_is_output)) == 8'h00)
        else $error("reduced drive on an input pin");
    a_pull_output_off: assert property ((p_pull_on & $past(p_pin_is_output)) == 8'h00)
        else $error("pull device on an output pin");
    a_pull_all_on: assert property (reg_wr && reg_addr == 4'h1 && reg_wdata == 8'hff
        ##1 p_pin_is_output == 8'h00 |=> p_pull_on == 8'hbf)
        else $error("pull enable not applied to input pins");
    a_pulldown_needs_pull: assert property ((p_pull_down & ~p_pull_on) == 8'h00)
        else $error("pull-down selected without pull enable");
    a_j_drive_dir: assert property ((j_pin_out & j_pin_oe_n) == 8'h00)
        else $error("second port data driven on a disabled pad");
    a_j_oe_mask: assert property ((~j_pin_oe_n & 8'h38) == 8'h00)
        else $error("unimplemented second port pad enabled");
    a_rsvd_read_zero: assert property (reg_rd && reg_addr inside {[4'h5:4'h7]}
        |=> reg_rdata == 8'h00)
        else $error("reserved register read nonzero");
    a_irq_masked: assert property (reg_wr && reg_addr == 4'h3 && reg_wdata == 8'h00
        |=> ##1 !p_irq)
        else $error("request stays up with all enables cleared");
    a_flags_clear: assert property (rst_age == 3'h7 && reg_wr && reg_addr == 4'h4
        && reg_wdata == 8'hff && $stable(p_pin_in) && $past(p_pin_in, 2) == $past(p_pin_in, 3)
        |=> ##1 !p_irq)
        else $error("request stays up after clearing every flag");
endmodule // ppc_port_properties

bind ppc_port ppc_port_properties #(.SYNC_STAGES(SYNC_STAGES)) ppc_port_properties_i (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p_pin_in(p_pin_in),
    .p_pin_is_output(p_pin_is_output), .p_reduced_drive(p_reduced_drive),
    .p_pull_on(p_pull_on), .p_pull_down(p_pull_down), .p_irq(p_irq), .j_pin_in(j_pin_in),
    .j_pin_out(j_pin_out), .j_pin_oe_n(j_pin_oe_n)
);

`default_nettype wire

//--- tb/ppc_port_test.sv
`default_nettype none

module ppc_port_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk = 1'b0;
    logic               srst = 1'b1;
    ppc_pkg::ppc_addr_t reg_addr = 4'h0;
    ppc_pkg::ppc_byte_t reg_wdata = 8'h00;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    ppc_pkg::ppc_byte_t p_pin_is_output = 8'h00;
    ppc_pkg::ppc_byte_t p_ext = 8'h00;
    ppc_pkg::ppc_byte_t j_ext = 8'h00;
    ppc_pkg::ppc_byte_t reg_rdata, p_pin_in, j_pin_in, p_reduced_drive, p_pull_on, p_pull_down;
    ppc_pkg::ppc_byte_t j_pin_out, j_pin_oe_n;
    logic               p_irq;
    int                 fail_count = 0;
    int                 cmp_count = 0;
    int                 cycles = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    ppc_port ppc_port_i (
        .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p_pin_in(p_pin_in),
        .p_pin_is_output(p_pin_is_output), .p_reduced_drive(p_reduced_drive),
        .p_pull_on(p_pull_on), .p_pull_down(p_pull_down), .p_irq(p_irq),
        .j_pin_in(j_pin_in), .j_pin_out(j_pin_out), .j_pin_oe_n(j_pin_oe_n)
    );

    ppc_board ppc_board_i (
        .p_ext(p_ext), .j_ext(j_ext), .j_pin_out(j_pin_out), .j_pin_oe_n(j_pin_oe_n),
        .p_pin_in(p_pin_in), .j_pin_in(j_pin_in)
    );

    // Whole run is well under a thousand cycles; a hang ends here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic chk(input string name, input ppc_pkg::ppc_byte_t exp,
                       input ppc_pkg::ppc_byte_t got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input ppc_pkg::ppc_addr_t a, input ppc_pkg::ppc_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input ppc_pkg::ppc_addr_t a, input ppc_pkg::ppc_byte_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Reset values, full-width access, reserved and unmapped places
    task automatic t_regs();
        for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
        for (int a = 0; a < 16; a++) wr(4'(a), 8'hff);
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), a < 4 ? 8'hbf : (a inside {[8:10]} ? 8'hc7 : 8'h00));
        end
        for (int a = 0; a < 16; a++) wr(4'(a), 8'h00);
    endtask

    // Pad controls against direction
    task automatic t_pads();
        p_pin_is_output <= 8'h0f;
        wr(4'h0, 8'ha5);
        wr(4'h1, 8'hdb);
        wr(4'h2, 8'h55);
        settle(2);
        chk("reduced drive", 8'h05, p_reduced_drive);
        chk("pull on", 8'h90, p_pull_on);
        chk("pull down", 8'h10, p_pull_down);
        @(posedge clk);
        p_pin_is_output <= 8'h00;
        for (int a = 0; a < 3; a++) wr(4'(a), 8'h00);
    endtask

    // Edge flags, masking and write-one-to-clear
    task automatic t_edges();
        wr(4'h2, 8'h01);
        wr(4'h3, 8'h01);
        p_ext <= 8'h01;
        settle(5);
        rd(4'h4, 8'h01);
        chk("irq", 8'h01, {7'h00, p_irq});
        p_ext <= 8'h03;
        settle(5);
        rd(4'h4, 8'h01);
        p_ext <= 8'h01;
        settle(5);
        rd(4'h4, 8'h03);
        wr(4'h4, 8'h02);
        rd(4'h4, 8'h01);
        wr(4'h4, 8'h00);
        rd(4'h4, 8'h01);
        wr(4'h3, 8'h00);
        settle(2);
        chk("irq masked", 8'h00, {7'h00, p_irq});
        wr(4'h3, 8'h01);
        settle(2);
        chk("irq unmasked", 8'h01, {7'h00, p_irq});
        wr(4'h4, 8'hff);
        settle(2);
        chk("irq cleared", 8'h00, {7'h00, p_irq});
        @(posedge clk);
        p_pin_is_output <= 8'h01;
        p_ext <= 8'h00;
        settle(5);
        p_ext <= 8'h01;
        settle(5);
        rd(4'h4, 8'h01);
        chk("irq output pin", 8'h01, {7'h00, p_irq});
        wr(4'h4, 8'hff);
        wr(4'h3, 8'h00);
        p_pin_is_output <= 8'h00;
    endtask

    // Second port data, direction and readback
    task automatic t_j();
        wr(4'h8, 8'h81);
        wr(4'ha, 8'h83);
        j_ext <= 8'h46;
        settle(4);
        chk("j out", 8'h81, j_pin_out);
        chk("j oe_n", 8'h7c, j_pin_oe_n);
        rd(4'h8, 8'hc5);
        rd(4'h9, 8'hc5);
        // Right after a data write the stored bit shows before the pin catches up
        wr(4'h8, 8'h01);
        rd(4'h8, 8'h45);
        settle(4);
        rd(4'h9, 8'h45);
        wr(4'ha, 8'h00);
        settle(4);
        chk("j oe_n off", 8'hff, j_pin_oe_n);
        chk("j out off", 8'h00, j_pin_out);
        rd(4'h8, 8'h46);
        rd(4'h9, 8'h46);
    endtask

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        settle(8);
        t_regs();
        t_pads();
        t_edges();
        t_j();
        conclude();
    end
endmodule // ppc_port_test

`default_nettype wire
